/* design/seps_pkg.sv */
/*
  Shared constants for the serial EEPROM programming block: command
  field layout, opcodes, array size, timing and idle/busy/ready state codes.
  Assumes a single 100 MHz system clock for the core.
*/
package seps_pkg;
   localparam int           WORD_W       = 16;
   localparam int           ADDR_W       = 6;
   localparam int           WORDS        = 64;
   localparam int           OP_W         = 2;
   localparam int           SHIFT_W      = 24;
   localparam int           CNT_W        = 5;
   localparam logic [4:0]   BITS_SHORT   = 5'h08;
   localparam logic [4:0]   BITS_LONG    = 5'h18;
   localparam int           OP_MSB       = 23;
   localparam int           ADDR_MSB     = 21;
   localparam int           CLK_PERIOD_NS = 10;
   localparam int           TIMER_W      = 24;

   localparam logic [1:0]   OP_SPECIAL   = 2'h0;
   localparam logic [1:0]   OP_WRITE     = 2'h1;
   localparam logic [1:0]   OP_READ      = 2'h2;
   localparam logic [1:0]   OP_ERASE     = 2'h3;
   localparam logic [1:0]   SUB_DISABLE  = 2'h0;
   localparam logic [1:0]   SUB_WRITE_ALL = 2'h1;
   localparam logic [1:0]   SUB_ERALL    = 2'h2;
   localparam logic [1:0]   SUB_ENABLE   = 2'h3;
   localparam logic [15:0]  ERASED_WORD  = 16'hFFFF;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_BUSY  = 3'h2,
      ST_READY = 3'h4
   } seps_state_type;

   // Commands that carry a 16-bit data field after the address
   function automatic logic seps_needs_data(input logic [1:0] op, input logic [1:0] sub);
      seps_needs_data = (op == OP_WRITE) || (op == OP_SPECIAL && sub == SUB_WRITE_ALL);
   endfunction : seps_needs_data
endpackage : seps_pkg

/* design/seps_link_if.sv */
/*
  Carrier between the serial-clock shifter and the system-clock core.
  Fields change only together with cmd_toggle, on a serial clock edge.
*/
`timescale 1ns/10ps
interface seps_link_if;
   logic        start_toggle;
   logic        cmd_toggle;
   logic [1:0]  cmd_op;
   logic [5:0]  cmd_addr;
   logic [15:0] cmd_data;
   modport link (output start_toggle, output cmd_toggle, output cmd_op, output cmd_addr, output cmd_data);
   modport core (input start_toggle, input cmd_toggle, input cmd_op, input cmd_addr, input cmd_data);
endinterface : seps_link_if

/* design/seps_sync.sv */
/*
  Two-flop level synchroniser, one lane per bit.
  Assumes inputs are levels or toggles that hold for several clocks.
*/
`timescale 1ns/10ps
module seps_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : seps_sync

/* design/seps_link.sv */
/*
  Serial-clock side: hunts for the start bit, shifts in opcode, address
  and data, and publishes each complete command by a toggle.
  Assumes the serial clock only runs while select is high.
*/
`timescale 1ns/10ps
module seps_link
   import seps_pkg::*;
(
   input  wire logic serial_clock_in,
   input  wire logic reset_n,
   input  wire logic device_select,
   input  wire logic serial_data_in,
   seps_link_if.link lnk
);
   logic               started;
   logic [CNT_W-1:0]   count;
   logic [SHIFT_W-1:0] shift;
   logic               frame_rst_n;
   logic [SHIFT_W-1:0] next_shift;
   logic [CNT_W-1:0]   next_count;
   logic               short_done;
   logic               long_done;

   // Deselect clears the framing, so each rising select starts afresh
   assign frame_rst_n = reset_n & device_select;
   assign next_shift  = {shift[SHIFT_W-2:0], serial_data_in};
   assign next_count  = count + 5'h01;
   assign short_done  = started && next_count == BITS_SHORT &&
                        !seps_needs_data(next_shift[7:6], next_shift[5:4]);
   assign long_done   = started && next_count == BITS_LONG;

   always_ff @(posedge serial_clock_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         started <= 1'b0;
         count   <= '0;
         shift   <= '0;
      end else if (!started) begin
         started <= serial_data_in;  // see R21
      end else if (count != BITS_LONG) begin
         count <= next_count;
         shift <= next_shift;
      end
   end

   // Published fields survive deselect; the core reads them after the frame
   always_ff @(posedge serial_clock_in or negedge reset_n) begin
      if (!reset_n) begin
         lnk.start_toggle <= 1'b0;
         lnk.cmd_toggle   <= 1'b0;
         lnk.cmd_op       <= '0;
         lnk.cmd_addr     <= '0;
         lnk.cmd_data     <= '0;
      end else begin
         if (device_select && !started && serial_data_in)
            lnk.start_toggle <= !lnk.start_toggle;  // see R18
         if (device_select && short_done) begin
            lnk.cmd_toggle <= !lnk.cmd_toggle;  // see R20
            lnk.cmd_op     <= next_shift[7:6];
            lnk.cmd_addr   <= next_shift[5:0];
         end else if (device_select && long_done) begin
            lnk.cmd_toggle <= !lnk.cmd_toggle;  // see R22
            lnk.cmd_op     <= next_shift[OP_MSB -: OP_W];
            lnk.cmd_addr   <= next_shift[ADDR_MSB -: ADDR_W];
            lnk.cmd_data   <= next_shift[WORD_W-1:0];
         end
      end
   end
endmodule : seps_link

/* design/seps_program_status.sv */
/*
  Programming and ready/busy core of a 64 x 16 serial EEPROM: decodes
  commands from the link, runs the self-timed programming cycle, holds
  the array and the write-enable state, and drives busy/ready on the
  data-out pin.
  Assumes the master frames commands with select and stops the serial
  clock once select falls; data-out is resolved by the bench from oe.
*/
// Behaviour
// R1: while programming is pending and select is high, data-out shows busy 0, ready 1.
// R2: status appears on data-out with no serial clock edges needed.
// R3: master raises select again only after the minimum select-low time.
// R4: master should issue no instruction while busy is reported.
// R5: master should issue write-disable after programming completes.
// R6: write-all programs every word with the one shifted-in 16-bit pattern.
// R7: write-all acts only while writing is enabled.
// R8: master drops select after the last bit, before the next clock edge.
// R9: select falling after a valid programming command starts the timed cycle.
// R10: for the whole programming time the device stays busy, accepting nothing.
// R11: write-disable blocks programming, taking effect when select falls.
// R12: reads behave the same whether writing is enabled or not.
// R13: erase sets every bit of the addressed word to one.
// R14: erase-all sets every bit of every word to one.
// R15: writes overwrite directly, no erase needed beforehand.
// R16: data-out is high impedance whenever select is low.
// R17: select may toggle freely during programming without affecting it.
// R18: ready stays driven until a start bit is clocked, then data-out releases.
// R19: lowering select after ready is shown resets the command logic.
// R20: command is start one, 2-bit opcode, 6-bit address; opcode 00 subcodes.
// R21: leading zeros are ignored; the first one sampled is the start bit.
// R22: data field is 16 bits, MSB first, sampled on rising serial clock.
// R23: device powers up write-disabled and rejects programming until enabled.
// R24: a disabled programming command starts no cycle and shows no busy.
`timescale 1ns/10ps
module seps_program_status
   import seps_pkg::*;
#(
   parameter int PROG_TIME_US = 5000
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        serial_clock_in,
   input  wire logic        device_select,
   input  wire logic        serial_data_in,
   output      logic        serial_data_out_o,
   output      logic        serial_data_out_oe,
   output      logic        write_enabled,
   output      logic        program_busy,
   input  wire logic [5:0]  mem_read_addr,
   output      logic [15:0] mem_read_data
);
   // Least time: round up to whole cycles
   localparam int                 PROG_CYCLES_INT = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [TIMER_W-1:0] PROG_CYCLES     = TIMER_W'(PROG_CYCLES_INT);
   localparam logic [TIMER_W-1:0] TIMER_LAST      = '0;
   localparam logic [5:0]         ADDR_FIRST      = 6'h00;
   localparam logic [5:0]         ADDR_LAST       = 6'h3F;

   seps_link_if lnk ();

   seps_link u_link (
      .serial_clock_in (serial_clock_in),
      .reset_n         (reset_n),
      .device_select   (device_select),
      .serial_data_in  (serial_data_in),
      .lnk             (lnk.link)
   );

   logic [2:0] sync_in;
   logic [2:0] sync_out;

   assign sync_in = {device_select, lnk.start_toggle, lnk.cmd_toggle};

   seps_sync #(.WIDTH(3)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (sync_in),
      .q       (sync_out)
   );

   logic                 sel_s;
   logic                 start_s;
   logic                 cmd_s;
   logic                 sel_d;
   logic                 start_d;
   logic                 cmd_d;
   logic                 cmd_pending;
   logic                 ready_shown;
   seps_state_type       state;
   seps_state_type       next_state;
   logic [TIMER_W-1:0]   timer;
   logic [1:0]           prog_op;
   logic [1:0]           prog_sub;
   logic [5:0]           prog_addr;
   logic [15:0]          prog_data;
   logic [WORD_W-1:0]    mem [WORDS];

   assign sel_s   = sync_out[2];
   assign start_s = sync_out[1];
   assign cmd_s   = sync_out[0];

   logic sel_rise;
   logic sel_fall;
   logic start_seen;
   logic cmd_seen;
   logic exec;
   logic is_special;
   logic is_enable;
   logic is_disable;
   logic is_write_all;
   logic is_erall;
   logic is_write;
   logic is_erase;
   logic is_prog;
   logic start_prog;
   logic prog_done;
   logic drive_status;

   assign sel_rise   = sel_s && !sel_d;
   assign sel_fall   = !sel_s && sel_d;
   assign start_seen = start_s != start_d;
   assign cmd_seen   = cmd_s != cmd_d;

   // Only a command completed inside the frame that just closed counts
   assign exec       = sel_fall && (cmd_pending || cmd_seen) && state == ST_IDLE;  // see R10

   assign is_special = lnk.cmd_op == OP_SPECIAL;
   assign is_enable  = is_special && lnk.cmd_addr[5:4] == SUB_ENABLE;
   assign is_disable = is_special && lnk.cmd_addr[5:4] == SUB_DISABLE;
   assign is_write_all = is_special && lnk.cmd_addr[5:4] == SUB_WRITE_ALL;
   assign is_erall   = is_special && lnk.cmd_addr[5:4] == SUB_ERALL;
   assign is_write   = lnk.cmd_op == OP_WRITE;
   assign is_erase   = lnk.cmd_op == OP_ERASE;
   assign is_prog    = is_write || is_erase || is_write_all || is_erall;

   assign start_prog = exec && is_prog && write_enabled;  // see R7 see R23 see R24 see R9
   assign prog_done  = state == ST_BUSY && timer == TIMER_LAST;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_d   <= 1'b0;
         start_d <= 1'b0;
         cmd_d   <= 1'b0;
      end else begin
         sel_d   <= sel_s;
         start_d <= start_s;
         cmd_d   <= cmd_s;
      end
   end

   // A new frame discards any half-seen command of the previous one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         cmd_pending <= 1'b0;
      else
         cmd_pending <= cmd_seen || (cmd_pending && !sel_rise && !sel_fall);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         write_enabled <= 1'b0;  // see R23
      else if (exec && is_enable)
         write_enabled <= 1'b1;
      else if (exec && is_disable)
         write_enabled <= 1'b0;  // see R11
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_prog)
               next_state = ST_BUSY;
         end
         ST_BUSY: begin
            // Select activity is not looked at here
            if (prog_done)
               next_state = ST_READY;  // see R17
         end
         ST_READY: begin
            if (start_seen)
               next_state = ST_IDLE;  // see R18
            else if (ready_shown && sel_fall)
               next_state = ST_IDLE;  // see R19
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         ready_shown <= 1'b0;
      else
         ready_shown <= state == ST_READY && (ready_shown || sel_s);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         timer <= '0;
      else if (start_prog)
         timer <= PROG_CYCLES - 24'h000001;  // see R10
      else if (state == ST_BUSY && timer != TIMER_LAST)
         timer <= timer - 24'h000001;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_op   <= OP_READ;
         prog_sub  <= SUB_DISABLE;
         prog_addr <= '0;
         prog_data <= '0;
      end else if (start_prog) begin
         prog_op   <= lnk.cmd_op;
         prog_sub  <= lnk.cmd_addr[5:4];
         prog_addr <= lnk.cmd_addr;
         prog_data <= lnk.cmd_data;
      end
   end

   // Array contents are nonvolatile, so they take no reset
   always_ff @(posedge clk) begin
      if (prog_done) begin
         for (int i = 0; i < WORDS; i++) begin
            if (prog_op == OP_SPECIAL && prog_sub == SUB_WRITE_ALL)
               mem[i] <= prog_data;  // see R6
            else if (prog_op == OP_SPECIAL && prog_sub == SUB_ERALL)
               mem[i] <= ERASED_WORD;  // see R14
         end
         if (prog_op == OP_WRITE)
            mem[prog_addr] <= prog_data;  // see R15
         else if (prog_op == OP_ERASE)
            mem[prog_addr] <= ERASED_WORD;  // see R13
      end
   end

   // Read port ignores write-enable entirely
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         mem_read_data <= '0;
      else
         mem_read_data <= mem[mem_read_addr];  // see R12
   end

   // Driven from the system clock so polling needs no serial clock
   assign drive_status = sel_s && (state == ST_BUSY || state == ST_READY);  // see R2

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_data_out_oe <= 1'b0;
         serial_data_out_o  <= 1'b0;
      end else begin
         serial_data_out_oe <= drive_status;  // see R16
         serial_data_out_o  <= drive_status && state == ST_READY;  // see R1
      end
   end

   assign program_busy = state == ST_BUSY;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_busy_drives_low: assert property (  // see R1
      (sel_s && state == ST_BUSY && timer != TIMER_LAST) |=> (serial_data_out_oe && !serial_data_out_o))
      else $error("busy not shown low on data-out");

   a_ready_drives_high: assert property (  // see R1
      (sel_s && state == ST_READY) |=> (serial_data_out_oe && serial_data_out_o))
      else $error("ready not shown high on data-out");

   a_deselect_high_z: assert property (  // see R16
      !sel_s |=> !serial_data_out_oe)
      else $error("data-out driven while deselected");

   a_fall_starts_prog: assert property (  // see R9
      (exec && is_prog && write_enabled) |=> (state == ST_BUSY && timer == PROG_CYCLES - 24'h000001))
      else $error("programming cycle not started on select fall");

   a_disabled_no_busy: assert property (  // see R24
      (exec && is_prog && !write_enabled) |=> (state == ST_IDLE) [*2])
      else $error("disabled command started programming");

   a_busy_holds_time: assert property (  // see R10
      (state == ST_BUSY && timer != TIMER_LAST) |=> (state == ST_BUSY && timer == $past(timer) - 24'h000001))
      else $error("programming ended early or timer stalled");

   a_busy_then_ready: assert property (  // see R10
      prog_done |=> state == ST_READY)
      else $error("ready not reached after programming time");

   a_disable_blocks: assert property (  // see R11
      (exec && is_disable) |=> !write_enabled ##1 !write_enabled)
      else $error("write-disable did not take effect");

   a_erase_sets_ones: assert property (  // see R13
      (prog_done && prog_op == OP_ERASE) |=> mem[$past(prog_addr)] == ERASED_WORD)
      else $error("erased word not all ones");

   a_write_all_fills: assert property (  // see R6
      (prog_done && prog_op == OP_SPECIAL && prog_sub == SUB_WRITE_ALL)
      |=> (mem[ADDR_FIRST] == $past(prog_data) && mem[ADDR_LAST] == $past(prog_data)))
      else $error("write-all pattern missing from array ends");

   a_start_clears: assert property (  // see R18
      (state == ST_READY && start_seen) |=> (state == ST_IDLE ##1 !serial_data_out_oe))
      else $error("start bit did not release data-out");

   a_ready_deselect: assert property (  // see R19
      (state == ST_READY && ready_shown && sel_fall) |=> state == ST_IDLE)
      else $error("deselect after ready did not reset");

   a_erall_fills: assert property (  // see R14
      (prog_done && prog_op == OP_SPECIAL && prog_sub == SUB_ERALL)
      |=> (mem[ADDR_FIRST] == ERASED_WORD && mem[ADDR_LAST] == ERASED_WORD))
      else $error("erase-all left a word not all ones");

   a_write_lands: assert property (  // see R15
      (prog_done && prog_op == OP_WRITE) |=> mem[$past(prog_addr)] == $past(prog_data))
      else $error("written word does not hold the new data");

   a_enable_sets: assert property (  // see R23
      (exec && is_enable) |=> write_enabled)
      else $error("write-enable did not take effect");

   a_fill_needs_enable: assert property (  // see R7
      (exec && is_write_all && !write_enabled) |=> !program_busy)
      else $error("write-all ran while writing was disabled");

   // Polling toggles select mid-cycle; the timer must not notice
   a_busy_ignores_select: assert property (  // see R17
      (state == ST_BUSY && timer != TIMER_LAST && (sel_rise || sel_fall))
      |=> (state == ST_BUSY && timer == $past(timer) - 24'h000001))
      else $error("select activity disturbed programming");

   a_ready_holds: assert property (  // see R18
      (state == ST_READY && !start_seen && !(ready_shown && sel_fall)) |=> state == ST_READY)
      else $error("ready cleared without start bit or deselect");

   a_idle_released: assert property (  // see R18
      state == ST_IDLE |=> !serial_data_out_oe)
      else $error("data-out driven with nothing to report");
endmodule : seps_program_status

/* bench/seps_master.sv */
/*
  Behavioural master of the serial link: frames commands with select,
  serial clock and data-in, and raises or drops select for polling.
  Assumes the bench top calls its tasks one at a time.
*/
`timescale 1ns/10ps
module seps_master (
   output logic device_select,
   output logic serial_clock_in,
   output logic serial_data_in
);
   localparam int HALF_NS = 24;
   localparam int LOW_NS  = 100;

   initial begin
      device_select   = 1'b0;
      serial_clock_in = 1'b0;
      serial_data_in  = 1'b1;
   end

   // Every rise waits out the select-low time first
   task automatic sel(input logic v);
      if (v) begin
         #(LOW_NS);
      end
      device_select = v;
   endtask : sel

   task automatic clock_bit(input logic b);
      serial_data_in = b;
      #(HALF_NS) serial_clock_in = 1'b1;
      #(HALF_NS) serial_clock_in = 1'b0;
   endtask : clock_bit

   // Clock stands still outside frames; data-in then shows a stale inverse
   task automatic frame(input int lead, input int n, input logic [23:0] bits, input bit keep);
      sel(1'b1);
      #7;
      repeat (lead) clock_bit(1'b0);
      clock_bit(1'b1);
      for (int i = n - 1; i >= 0; i--) begin
         clock_bit(bits[i]);
      end
      if (!keep) begin
         #5 device_select = 1'b0;
         serial_data_in = ~serial_data_in;
      end
   endtask : frame
endmodule : seps_master

/* bench/tb_top.sv */
/*
  Self-checking bench for the programming and status core.
  Assumes the master model frames every command and the core runs on clk.
*/
`timescale 1ns/10ps
module tb_top
   import seps_pkg::*;
;
   localparam int PT_US    = 1;
   localparam int PROG_CYC = PT_US * 1000 / CLK_PERIOD_NS;

   logic        clk;
   logic        reset_n;
   logic [5:0]  mem_read_addr;
   logic        device_select, serial_clock_in, serial_data_in;
   logic        o, oe, write_enabled, program_busy;
   logic [15:0] mem_read_data;
   wire         sdo = oe ? o : 1'bz;
   int          bad_count = 0;
   int          checked = 0;
   int          cnt = 0;
   logic [15:0] exp_q[$];
   int          sel_q[$];
   event        look;
   logic [15:0] d_all, e_wr;
   logic [5:0]  a_er, b_wr;
   localparam logic [15:0] HIZ = {15'h0000, 1'bz};

   always #5 clk = ~clk;

   seps_master seps_master_i (
      .device_select   (device_select),
      .serial_clock_in (serial_clock_in),
      .serial_data_in  (serial_data_in)
   );

   seps_program_status #(.PROG_TIME_US(PT_US)) seps_program_status_i (
      .clk                (clk),
      .reset_n            (reset_n),
      .serial_clock_in    (serial_clock_in),
      .device_select      (device_select),
      .serial_data_in     (serial_data_in),
      .serial_data_out_o  (o),
      .serial_data_out_oe (oe),
      .write_enabled      (write_enabled),
      .program_busy       (program_busy),
      .mem_read_addr      (mem_read_addr),
      .mem_read_data      (mem_read_data)
   );

   task automatic finish_test;
      $display("bad_count %0d checked %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [15:0] obs(input int s);
      case (s)
         0: obs = {15'h0000, program_busy};
         1: obs = {15'h0000, write_enabled};
         2: obs = {15'h0000, sdo};
         3: obs = mem_read_data;
         default: obs = 16'(cnt);
      endcase
   endfunction : obs

   // Oldest note pairs with the result now shown
   always @(look) begin
      while (sel_q.size() > 0) begin
         chk(obs(sel_q.pop_front()), exp_q.pop_front());
      end
   end

   task automatic expect_val(input int s, input logic [15:0] e);
      sel_q.push_back(s);
      exp_q.push_back(e);
      -> look;
   endtask : expect_val

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk

   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      mem_read_addr = a;
      wait_clk(2);
      expect_val(3, e);
   endtask : rd

   task automatic rd_all(input logic [15:0] e);
      for (int a = 0; a < WORDS; a++) begin
         rd(6'(a), e);
      end
   endtask : rd_all

   task automatic cmd(input logic [7:0] b);
      seps_master_i.frame($urandom % 4, 8, {16'h0000, b}, 1'b0);
      wait_clk(10);
   endtask : cmd

   task automatic prog(input logic [23:0] b, input int n, input bit by_start);
      int i;
      seps_master_i.frame($urandom % 4, n, b, 1'b0);
      fork
         begin
            i = 0;
            while (program_busy !== 1'b1 && i < 20) begin
               wait_clk(1);
               i++;
            end
            if (i == 20) begin
               bad_count++;
               $display("[ERR] %0t busy never rose", $time);
               finish_test();
            end
            cnt = 0;
            while (program_busy === 1'b1 && cnt < 300) begin
               wait_clk(1);
               cnt++;
            end
         end
         begin
            seps_master_i.sel(1'b1);
            wait_clk(6);
            expect_val(2, 16'h0000);
            seps_master_i.sel(1'b0);
            wait_clk(6);
            expect_val(2, HIZ);
            seps_master_i.sel(1'b1);
            wait_clk(6);
            seps_master_i.sel(1'b0);
         end
      join
      expect_val(4, 16'(PROG_CYC));
      seps_master_i.sel(1'b1);
      wait_clk(6);
      expect_val(2, 16'h0001);
      if (by_start) begin
         seps_master_i.frame(0, 0, 24'h000000, 1'b1);
         wait_clk(8);
         expect_val(2, HIZ);
      end
      seps_master_i.sel(1'b0);
      wait_clk(6);
   endtask : prog

   initial begin
      clk           = 1'b0;
      reset_n       = 1'b0;
      void'($urandom(97933));
      mem_read_addr = 6'($urandom);
      repeat (6) @(posedge clk);
      #1 reset_n = 1'b1;
      wait_clk(3);
      expect_val(1, 16'h0000);
      expect_val(0, 16'h0000);
      d_all = 16'($urandom);
      seps_master_i.frame(1, 24, {OP_SPECIAL, SUB_WRITE_ALL, 4'h0, d_all}, 1'b0);
      wait_clk(20);
      expect_val(0, 16'h0000);
      cmd({OP_SPECIAL, SUB_ENABLE, 4'h0});
      expect_val(1, 16'h0001);
      prog({OP_SPECIAL, SUB_WRITE_ALL, 4'h0, d_all}, 24, 1'b1);
      rd_all(d_all);
      a_er = 6'($urandom);
      prog({16'h0000, OP_ERASE, a_er}, 8, 1'b0);
      rd(a_er, ERASED_WORD);
      rd(a_er ^ 6'h01, d_all);
      b_wr = a_er ^ 6'h20;
      e_wr = 16'($urandom);
      prog({OP_WRITE, b_wr, e_wr}, 24, 1'b1);
      rd(b_wr, e_wr);
      prog({16'h0000, OP_SPECIAL, SUB_ERALL, 4'h0}, 8, 1'b0);
      rd_all(ERASED_WORD);
      cmd({OP_SPECIAL, SUB_DISABLE, 4'h0});
      expect_val(1, 16'h0000);
      seps_master_i.frame(0, 8, {16'h0000, OP_ERASE, b_wr}, 1'b0);
      wait_clk(20);
      expect_val(0, 16'h0000);
      rd(b_wr, ERASED_WORD);
      finish_test();
   end
endmodule : tb_top
